// File: qdl_consts.svh
// Overview of operation
// - A transfer is sixteen serial bits, most significant bit first.
// - Word splits into two channel bits, two command bits, twelve code bits.
// - Channel and command bits pick registers, latching and the echo edge.
// - Select high ignores clock and data; echo is released high.
// - Select low shifts serial input into the shift register on rising clock.
// - Select rising edge decodes the word and updates the chosen registers.
// - Load-all writes one code into every input and converter register.
// - No-operation command leaves every input and converter register unchanged.
// - Either echo-edge command also copies all input registers to converters.
// - Echo shows shift register output; mode one rising, mode zero falling.
// - In mode zero the echo lags the input by sixteen and a half clocks.
// - In mode one the echo lags the input by exactly sixteen clocks.
// - After power-up the echo runs in mode one.
// - Load pin high gives double buffering with input-only, direct or update-all.
// - Load pin low makes converters transparent, updating at select rise.
// - Load pin low copies all input registers into the converter registers.
// - No readback of input or converter registers; only the shift register echoes.
// - Code is straight unsigned binary, output equals code times reference over 4096.
// - Channel values zero to three address A to D; commands 01 and 11 as listed.
// - Command 00 loads all or is a no-op by low channel bit; 10 updates all.
// - Command 10 with channel 11 selects mode one, with channel 10 mode zero.
`ifndef QDL_CONSTS_SVH
`define QDL_CONSTS_SVH
`define QDL_WORD_W 16
`define QDL_CODE_W 12
`define QDL_NUM_CH 4
`define QDL_CMD_LOAD_ALL 2'h0
`define QDL_CMD_IN_ONLY 2'h1
`define QDL_CMD_UPDATE 2'h2
`define QDL_CMD_IN_UPD 2'h3
`define QDL_CHAN_MODE1 2'h3
`define QDL_CHAN_MODE0 2'h2
`define QDL_MODE_RESET 1'h1
`define QDL_CODE_RESET 12'h000
`define QDL_WORD_RESET 16'h0000
`define QDL_PIN_IDLE 1'h1
`define QDL_ECHO_IDLE 1'h1
`define QDL_LAG_FULL 5'h10
`define QDL_LAG_ZERO 5'h00
`define QDL_LAG_ONE 5'h01
`endif

// File: qdl_pkg.sv
`include "qdl_consts.svh"
package qdl_pkg;
   // Command field codes
   typedef enum logic [1:0] {
      QDL_LOAD_ALL = `QDL_CMD_LOAD_ALL,
      QDL_IN_ONLY = `QDL_CMD_IN_ONLY,
      QDL_UPDATE = `QDL_CMD_UPDATE,
      QDL_IN_UPD = `QDL_CMD_IN_UPD
   } qdl_cmd_t;
   typedef logic [`QDL_CODE_W-1:0] qdl_code_t;
   // Serial word layout, most significant field first
   typedef struct packed {
      logic [1:0] chan;
      qdl_cmd_t cmd;
      qdl_code_t code;
   } qdl_word_t;
endpackage : qdl_pkg

// File: qdl_loader.sv
`timescale 1ns/1ns
`include "qdl_consts.svh"
module qdl_loader import qdl_pkg::*; #(
   parameter int NUM_CH = `QDL_NUM_CH
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic serial_in_i,
   input wire logic load_outputs_n_i,
   output logic echo_out_o,
   output logic echo_out_oe_o,
   output logic echo_mode_o,
   output qdl_code_t converter_code_o [NUM_CH]
);

   ////////////////////////////////////////////////////////////////////////////
   // Link clock domain: shift register and echo
   logic [`QDL_WORD_W-1:0] sr_r;
   logic [`QDL_WORD_W-1:0] sr_nxt;
   logic half_r;
   logic half_nxt;
   logic mode_meta_r;
   logic mode_lk_r;
   logic mode_r;

   // Shift on rising clock only while selected; old bits fall off the top
   always_comb begin
      sr_nxt = sr_r;
      if (!cs_n_i) begin
         sr_nxt = {sr_r[`QDL_WORD_W-2:0], serial_in_i};
      end
   end

   // Shift register and mode synchroniser
   always_ff @(posedge sck_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sr_r <= `QDL_WORD_RESET;
         mode_meta_r <= `QDL_MODE_RESET;
         mode_lk_r <= `QDL_MODE_RESET;
      end else begin
         sr_r <= sr_nxt;
         mode_meta_r <= mode_r;
         mode_lk_r <= mode_meta_r;
      end
   end

   // Half-cycle retimed copy of the top bit for mode zero
   always_comb begin
      half_nxt = half_r;
      if (!cs_n_i) begin
         half_nxt = sr_r[`QDL_WORD_W-1];
      end
   end

   always_ff @(negedge sck_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         half_r <= `QDL_ECHO_IDLE;
      end else begin
         half_r <= half_nxt;
      end
   end

   // Echo pin: released and idle high when deselected
   always_comb begin
      echo_out_oe_o = !cs_n_i;
      if (cs_n_i) begin
         echo_out_o = `QDL_ECHO_IDLE;
      end else if (mode_lk_r) begin
         echo_out_o = sr_r[`QDL_WORD_W-1];
      end else begin
         echo_out_o = half_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference clock domain: pin synchronisers and select edge
   logic cs_meta_r;
   logic cs_sync_r;
   logic cs_dly_r;
   logic ld_meta_r;
   logic ld_sync_r;
   logic cs_rise;
   logic ld_low;
   qdl_word_t word;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_meta_r <= `QDL_PIN_IDLE;
         cs_sync_r <= `QDL_PIN_IDLE;
         cs_dly_r <= `QDL_PIN_IDLE;
         ld_meta_r <= `QDL_PIN_IDLE;
         ld_sync_r <= `QDL_PIN_IDLE;
      end else begin
         cs_meta_r <= cs_n_i;
         cs_sync_r <= cs_meta_r;
         cs_dly_r <= cs_sync_r;
         ld_meta_r <= load_outputs_n_i;
         ld_sync_r <= ld_meta_r;
      end
   end

   // Shift register is frozen while deselected, so it is read once the edge is seen
   assign cs_rise = cs_sync_r && !cs_dly_r;
   assign word = qdl_word_t'(sr_r);
   assign ld_low = !ld_sync_r;

   ////////////////////////////////////////////////////////////////////////////
   // Input and converter registers, one set per channel
   qdl_code_t in_r [NUM_CH];
   qdl_code_t in_nxt [NUM_CH];
   qdl_code_t dac_r [NUM_CH];
   qdl_code_t dac_nxt [NUM_CH];
   logic mode_nxt;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         // Decode one word; load pin low makes the converter follow its input
         always_comb begin
            in_nxt[g] = in_r[g];
            dac_nxt[g] = dac_r[g];
            if (cs_rise) begin
               unique case (word.cmd)
                  QDL_IN_ONLY: begin
                     if (word.chan == 2'(g)) begin
                        in_nxt[g] = word.code;
                     end
                  end
                  QDL_IN_UPD: begin
                     if (word.chan == 2'(g)) begin
                        in_nxt[g] = word.code;
                     end
                     dac_nxt[g] = in_nxt[g];
                  end
                  QDL_LOAD_ALL: begin
                     if (!word.chan[0]) begin
                        in_nxt[g] = word.code;
                        dac_nxt[g] = word.code;
                     end
                  end
                  QDL_UPDATE: begin
                     dac_nxt[g] = in_r[g];
                  end
               endcase
            end
            if (ld_low) begin
               dac_nxt[g] = in_nxt[g];
            end
         end

         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               in_r[g] <= `QDL_CODE_RESET;
               dac_r[g] <= `QDL_CODE_RESET;
            end else begin
               in_r[g] <= in_nxt[g];
               dac_r[g] <= dac_nxt[g];
            end
         end

         // Straight binary code to the converter core
         assign converter_code_o[g] = dac_r[g];
      end
   endgenerate

   // Echo edge mode
   always_comb begin
      mode_nxt = mode_r;
      if (cs_rise && word.cmd == QDL_UPDATE) begin
         if (word.chan == `QDL_CHAN_MODE1) begin
            mode_nxt = 1'b1;
         end else if (word.chan == `QDL_CHAN_MODE0) begin
            mode_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_r <= `QDL_MODE_RESET;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   assign echo_mode_o = mode_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [4:0] lag_cnt_r;
   logic [4:0] lag_cnt_nxt;

   // Count consecutive selected rising edges, saturating at one word
   always_comb begin
      lag_cnt_nxt = `QDL_LAG_ZERO;
      if (!cs_n_i) begin
         lag_cnt_nxt = (lag_cnt_r == `QDL_LAG_FULL) ? lag_cnt_r : lag_cnt_r + `QDL_LAG_ONE;
      end
   end

   always_ff @(posedge sck_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lag_cnt_r <= `QDL_LAG_ZERO;
      end else begin
         lag_cnt_r <= lag_cnt_nxt;
      end
   end

   sequence s_cmd(qdl_cmd_t c);
      cs_rise && word.cmd == c;
   endsequence

   sequence s_mode_cmd(logic [1:0] ch);
      s_cmd(QDL_UPDATE) ##0 (word.chan == ch);
   endsequence

   a_shift_capture: assert property (@(posedge sck_i) disable iff (!arst_n_i)
      !cs_n_i |=> sr_r[0] == $past(serial_in_i))
      else $error("shift register missed serial input");

   a_echo_lag_one: assert property (@(posedge sck_i) disable iff (!arst_n_i)
      (!cs_n_i && mode_lk_r && lag_cnt_r == `QDL_LAG_FULL) |-> echo_out_o == $past(serial_in_i, 16))
      else $error("mode one echo lag not sixteen");

   a_echo_half_lag: assert property (@(negedge sck_i) disable iff (!arst_n_i)
      !cs_n_i |=> half_r == $past(sr_r[15]))
      else $error("mode zero echo not retimed");

   a_echo_idle_high: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      cs_n_i |-> (echo_out_o && !echo_out_oe_o))
      else $error("echo driven while deselected");

   a_load_all_cmd: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_cmd(QDL_LOAD_ALL) ##0 !word.chan[0]) |=> (dac_r[0] == $past(word.code)
      && in_r[3] == $past(word.code) && dac_r[3] == in_r[3]))
      else $error("load-all did not reach every register");

   a_nop_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_cmd(QDL_LOAD_ALL) ##0 word.chan[0] && ld_sync_r) |=> ($stable(in_r[0])
      && $stable(dac_r[0]) && $stable(in_r[3]) && $stable(dac_r[3])))
      else $error("no-operation changed a register");

   a_input_only: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_cmd(QDL_IN_ONLY) ##0 ld_sync_r && word.chan == 2'h1) |=> (in_r[1] == $past(word.code)
      && $stable(dac_r[1])))
      else $error("input-only write touched converter");

   a_mode_zero_cmd: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      s_mode_cmd(`QDL_CHAN_MODE0) |=> !mode_r ##1 !mode_r)
      else $error("mode zero not selected");

   a_mode_one_copy: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      s_mode_cmd(`QDL_CHAN_MODE1) |=> (mode_r && dac_r[2] == in_r[2]))
      else $error("mode one command failed to update");

   a_load_pin_copy: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      ld_low |=> (dac_r[0] == in_r[0] && dac_r[1] == in_r[1]))
      else $error("load pin low did not copy inputs");

   a_decode_once: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      cs_rise |=> !cs_rise [*2])
      else $error("word decoded twice");

   // Selected in mode zero on two falling edges in a row
   sequence s_mode0_sel;
      !cs_n_i && !mode_lk_r;
   endsequence

   a_mode_zero_echo: assert property (@(negedge sck_i) disable iff (!arst_n_i)
      s_mode0_sel ##1 s_mode0_sel |-> echo_out_o == $past(sr_r[15]))
      else $error("mode zero echo not half a clock late");

   a_update_all: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_cmd(QDL_UPDATE) ##0 !word.chan[1]) |=> (dac_r[0] == $past(in_r[0])
      && dac_r[3] == $past(in_r[3])))
      else $error("update command did not copy inputs");

   a_input_update: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      s_cmd(QDL_IN_UPD) |=> (dac_r[0] == in_r[0] && dac_r[1] == in_r[1]
      && dac_r[2] == in_r[2] && dac_r[3] == in_r[3]))
      else $error("input and update command left a converter stale");

   a_load_transparent: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_cmd(QDL_IN_ONLY) ##0 ld_low && word.chan == 2'h2) |=> dac_r[2] == $past(word.code))
      else $error("transparent converter missed its input");

   a_mode_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (cs_rise && !(word.cmd == QDL_UPDATE && word.chan[1])) |=> $stable(mode_r))
      else $error("echo mode changed by a data command");

   a_quiet_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (!cs_rise && ld_sync_r) |=> ($stable(in_r[1]) && $stable(dac_r[1]) && $stable(mode_r)))
      else $error("register changed with no decode");

   a_word_settled: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      cs_rise |-> $stable(sr_r))
      else $error("shift register moved during decode");

endmodule : qdl_loader

// File: qdl_host_model.sv
`timescale 1ns/1ns
// Host serial master: frames of n bits, shift clock only inside frames
module qdl_host_model (
   output logic sck_o,
   output logic cs_n_o,
   output logic sdi_o,
   input wire logic echo_i
);
   // Word sent as two bytes with a pause when set
   bit split;

   // Idle lines at time zero
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
      split = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One frame, MSB first, echo sampled in the high phase of each clock
   task automatic send(input logic [31:0] w, input int n, output logic [15:0] cap);
      cap = 16'h0000;
      #3 cs_n_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         if (split && i == 7) #128; // Byte pause, clock held low
         sdi_o = w[i];
         #32 sck_o = 1'b1;
         #16 cap = {cap[14:0], echo_i};
         #16 sck_o = 1'b0;
      end
      #32 cs_n_o = 1'b1;
      sdi_o = ~sdi_o; // Released line shows no stale value
      #200;
   endtask : send
endmodule : qdl_host_model

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top import qdl_pkg::*;;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic ld = 1'b1;
   logic sck, cs_n, serial_in, echo_o, echo_oe, echo_mode_o;
   wire logic echo_w = echo_oe ? echo_o : 1'b1; // Pull-up on released pin
   qdl_code_t codes [4];
   qdl_code_t inp [4] = '{4{12'h000}};
   qdl_code_t dac [4] = '{4{12'h000}};
   logic mode = 1'b1;
   logic [15:0] last_cap;
   int err_count = 0;
   int num_checks = 0;

   // Clock
   always #4 ref_clk = ~ref_clk;

   qdl_host_model host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(serial_in), .echo_i(echo_w));
   qdl_loader dut (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .sck_i(sck), .cs_n_i(cs_n),
      .serial_in_i(serial_in), .load_outputs_n_i(ld), .echo_out_o(echo_o),
      .echo_out_oe_o(echo_oe), .echo_mode_o(echo_mode_o), .converter_code_o(codes));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   // Expected register effects of one decoded word
   task automatic model(input logic [15:0] w);
      case (w[13:12])
         2'h1: begin
            inp[w[15:14]] = w[11:0];
            if (!ld) dac[w[15:14]] = w[11:0];
         end
         2'h3: begin
            inp[w[15:14]] = w[11:0];
            dac = inp;
         end
         2'h0: if (!w[14]) begin
            inp = '{4{w[11:0]}};
            dac = inp;
         end
         default: begin
            if (w[15:14] == 2'h3) mode = 1'b1;
            if (w[15:14] == 2'h2) mode = 1'b0;
            dac = inp;
         end
      endcase
   endtask : model

   task automatic cmp_all();
      for (int i = 0; i < 4; i++) check(16'(codes[i]), 16'(dac[i]));
      check(16'(echo_mode_o), 16'(mode));
      check({14'h0000, echo_oe, echo_o}, 16'h0001);
   endtask : cmp_all

   task automatic xfer(input logic [31:0] w, input int n);
      logic [15:0] cap;
      host.send(w, n, cap);
      last_cap = cap;
      model(w[15:0]);
      repeat (6) @(posedge ref_clk);
      #1;
      cmp_all();
   endtask : xfer

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_dbuf();
      for (int i = 0; i < 4; i++) xfer(32'({i[1:0], 2'h1, 12'h3a0 + 12'(i)}), 16);
      xfer(32'h0000_2000, 16);
      xfer(32'h0000_7fff, 16);
      $display("test dbuf done");
   endtask : t_dbuf

   task automatic t_all();
      host.split = 1'b1;
      xfer(32'h0000_0ab7, 16);
      xfer(32'h0000_8555, 16);
      xfer(32'h0000_4123, 16);
      xfer(32'h0000_c456, 16);
      host.split = 1'b0;
      $display("test all done");
   endtask : t_all

   task automatic t_pin();
      xfer(32'h0000_1321, 16);
      @(posedge ref_clk) ld <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      dac = inp;
      cmp_all();
      xfer(32'h0000_9777, 16);
      @(posedge ref_clk) ld <= 1'b1;
      repeat (4) @(posedge ref_clk);
      $display("test pin done");
   endtask : t_pin

   task automatic t_echo();
      xfer(32'h000f_3123, 20);
      xfer(32'h0000_4a5c, 16);
      xfer(32'h0000_4000, 16);
      check(last_cap, 16'h94b8);
      xfer(32'h0000_d0c1, 16);
      xfer(32'h0000_a000, 16);
      xfer(32'h0000_4a5c, 16);
      xfer(32'h0000_4000, 16);
      check(last_cap, 16'h4a5c);
      xfer(32'h0000_e000, 16);
      $display("test echo done");
   endtask : t_echo

   task automatic t_reset();
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      cmp_all();
      check(16'(echo_mode_o), 16'h0001);
      $display("test reset done");
   endtask : t_reset

   // Main sequence
   initial begin
      t_reset();
      t_dbuf();
      t_all();
      t_pin();
      t_echo();
      summarize();
   end

   // Watchdog
   initial begin
      #300000;
      check(16'h0000, 16'h0001);
      summarize();
   end
endmodule : tb_top
